// [core/sipo_latch.sv]
// Serial-in parallel-out shift register with buffered storage register and three-state outputs
//
// Functional notes
// (R1) Shift clock edge shifts data in
// (R2) Eight-bit shift and storage registers
// (R3) Low clear zeroes shift stages asynchronously
// (R4) Storage clock edge copies shift stages unless the snapshot buffer is full
// (R5) Output enable high floats parallel outputs
// (R6) Last stage drives cascade serial output
// (R7) Tied clocks: storage lags one pulse
// (R8) Clear leaves storage register untouched
`timescale 1ns/10ps
module sipo_latch
    import sipo_latch_pkg::*;
(
    input  wire logic             core_clk_in,       // Core clock, 10 MHz
    input  wire logic             rst_in,            // Synchronous reset, active high
    input  wire logic             clk_en_in,         // Freezes all core state while low
    input  wire logic             shift_clock_in,    // Link clock: shift clock, rising edge
    input  wire logic             shift_data_in,     // Serial data, sampled on shift clock
    input  wire logic             shift_clear_n_in,  // Shift register clear, active low
    input  wire logic             store_clock_in,    // Storage clock pin, rising edge
    input  wire logic             out_en_n_in,       // Output enable, active low
    input  wire logic             sink_ready_in,     // Receiver of the parallel word ready
    output logic [WIDTH-1:0]      par_data_out,      // Parallel output drive value
    output logic [WIDTH-1:0]      par_oe_out,        // Parallel output enables, high drives
    output logic                  ser_cascade_out,   // Last shift stage, for cascading
    output logic                  word_valid_out,    // Storage register word available
    output logic                  snap_ready_out     // Buffer can take a new snapshot
);

    // ****************************************
    // Link domain: shift register
    // ****************************************
    logic [WIDTH-1:0] stage_ff;
    logic [WIDTH-1:0] nxt_stage;

    assign nxt_stage = {stage_ff[WIDTH-2:0], shift_data_in};   // R1

    // Clear is a real async override on the link clock, like the pin it models
    always_ff @(posedge shift_clock_in or negedge shift_clear_n_in) begin
        if (!shift_clear_n_in) begin
            stage_ff <= STAGE_ZERO;   // R3
        end else begin
            stage_ff <= nxt_stage;    // R1 R2
        end
    end

    // Marks a clear since the last shift edge; the shift checks skip that edge
    // because the stages were zeroed between two ticks of their own clock
    logic clear_seen_ff;

    always_ff @(posedge shift_clock_in or negedge shift_clear_n_in) begin
        if (!shift_clear_n_in) begin
            clear_seen_ff <= 1'b1;
        end else begin
            clear_seen_ff <= 1'b0;
        end
    end

    // ****************************************
    // Core domain: synchronisers
    // ****************************************
    logic [SYNC_DEPTH-1:0] st_clk_sync_ff;
    logic                  st_clk_prev_ff;
    logic [SYNC_DEPTH-1:0] oe_sync_ff;
    logic [WIDTH-1:0]      stage_s1_ff;
    logic [WIDTH-1:0]      stage_s2_ff;
    logic [WIDTH-1:0]      stage_lag_ff;
    logic [SYNC_DEPTH-1:0] casc_sync_ff;
    logic                  store_rise;

    // Shift stages only move on shift clock edges or a clear; the host keeps them still
    // before a store edge, so two-flop sampling of the word is coherent
    // A third lag flop hands the store the word seen before its own edge
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_clk_sync_ff <= '0;
            st_clk_prev_ff <= 1'b0;
            oe_sync_ff     <= '1;
            stage_s1_ff    <= STAGE_ZERO;
            stage_s2_ff    <= STAGE_ZERO;
            stage_lag_ff   <= STAGE_ZERO;
            casc_sync_ff   <= '0;
        end else if (clk_en_in) begin
            st_clk_sync_ff <= {st_clk_sync_ff[0], store_clock_in};
            st_clk_prev_ff <= st_clk_sync_ff[1];
            oe_sync_ff     <= {oe_sync_ff[0], out_en_n_in};
            stage_s1_ff    <= stage_ff;
            stage_s2_ff    <= stage_s1_ff;
            stage_lag_ff   <= stage_s2_ff;   // R7
            casc_sync_ff   <= {casc_sync_ff[0], stage_ff[LAST_STAGE]};
        end
    end

    // Storage edge seen; snapshot lags the shift stages so tied clocks see old data
    assign store_rise = clk_en_in & st_clk_sync_ff[1] & ~st_clk_prev_ff;   // R7

    // ****************************************
    // Snapshot buffer (two entries)
    // ****************************************
    logic [WIDTH-1:0] buf_mem_ff [BUF_DEPTH];
    logic             wr_ptr_ff;
    logic             rd_ptr_ff;
    logic [1:0]       count_ff;
    logic [1:0]       nxt_count;
    logic             buf_full;
    logic             buf_empty;
    logic             push;
    logic             pop;
    logic             out_load;

    assign buf_full  = (count_ff == 2'(BUF_DEPTH));
    assign buf_empty = (count_ff == 2'h0);
    assign push      = store_rise & ~buf_full;                   // R4
    assign out_load  = ~buf_empty & (~word_valid_out | sink_ready_in);
    assign pop       = clk_en_in & out_load;
    // Next fill level, shared by the counter and the registered ready flag
    assign nxt_count = count_ff + 2'(push) - 2'(pop);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            if (push) begin
                buf_mem_ff[wr_ptr_ff] <= stage_lag_ff;           // R4 R7
                wr_ptr_ff             <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            count_ff <= nxt_count;
        end
    end

    // ****************************************
    // Storage register and pin drive
    // ****************************************
    // Storage only changes on a pop or a reset, so clear never reaches it
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            par_data_out    <= STAGE_ZERO;
            par_oe_out      <= '0;
            ser_cascade_out <= 1'b0;
            word_valid_out  <= 1'b0;
            snap_ready_out  <= 1'b1;
        end else if (clk_en_in) begin
            if (out_load) begin
                par_data_out <= buf_mem_ff[rd_ptr_ff];           // R2 R8
            end
            if (out_load) begin
                word_valid_out <= 1'b1;
            end else if (sink_ready_in) begin
                word_valid_out <= 1'b0;
            end
            par_oe_out      <= {WIDTH{~oe_sync_ff[1]}};          // R5
            ser_cascade_out <= casc_sync_ff[1];                  // R6
            // Taken from the next fill level so it drops on the filling edge
            snap_ready_out  <= (nxt_count != 2'(BUF_DEPTH));     // R4
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    oe_follows_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R5
        clk_en_in |=> par_oe_out == {WIDTH{~$past(oe_sync_ff[1])}})
        else $error("output enable not following pin");
    casc_last_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R6
        clk_en_in |=> ser_cascade_out == $past(casc_sync_ff[1]))
        else $error("cascade output not last stage");
    clear_zero_a: assert property (@(posedge shift_clock_in)   // R3
        !shift_clear_n_in |-> stage_ff == STAGE_ZERO)
        else $error("shift stages not cleared");
    shift_move_a: assert property (@(posedge shift_clock_in) disable iff (!shift_clear_n_in)   // R1
        !clear_seen_ff |-> stage_ff[WIDTH-1:1] == $past(stage_ff[WIDTH-2:0]))
        else $error("shift stages did not move");
    store_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R8
        !out_load |=> $stable(par_data_out))
        else $error("storage changed without store");
    store_push_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R4
        push |=> buf_mem_ff[$past(wr_ptr_ff)] == $past(stage_lag_ff))
        else $error("snapshot not captured");
    buf_bound_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R2
        count_ff <= 2'(BUF_DEPTH))
        else $error("buffer overfilled");
    lag_stage_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R7
        clk_en_in ##1 clk_en_in |=> stage_lag_ff == $past(stage_s2_ff))
        else $error("snapshot path not lagging");
    // Buffer, storage load, word valid, ready flag and clock-enable checks
    ready_full_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R4
        snap_ready_out == (count_ff != 2'(BUF_DEPTH)))
        else $error("ready flag not matching fill level");
    full_refuse_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R4
        store_rise && buf_full && !pop |=> count_ff == 2'(BUF_DEPTH))
        else $error("store taken while buffer full");
    push_count_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R4
        push && !pop |=> count_ff == $past(count_ff) + 2'h1)
        else $error("fill level did not rise on store");
    ptr_track_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R4
        buf_empty |-> wr_ptr_ff == rd_ptr_ff)
        else $error("buffer pointers apart while empty");
    load_data_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R2
        out_load && clk_en_in |=> par_data_out == $past(buf_mem_ff[rd_ptr_ff]))
        else $error("storage register not loaded from buffer");
    valid_load_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R4
        out_load && clk_en_in |=> word_valid_out)
        else $error("word valid not raised on load");
    valid_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R8
        word_valid_out && !sink_ready_in |=> word_valid_out)
        else $error("word valid dropped while stalled");
    freeze_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)   // R2
        !clk_en_in |=> $stable(par_data_out) && $stable(par_oe_out) && $stable(word_valid_out))
        else $error("outputs moved while clock enable low");
    // Link domain: the first stage takes the data pin
    shift_first_a: assert property (@(posedge shift_clock_in) disable iff (!shift_clear_n_in)   // R1
        !clear_seen_ff |-> stage_ff[0] == $past(shift_data_in))
        else $error("first stage missed the data pin");

endmodule

// [core/sipo_latch_pkg.sv]
// Constants shared by the serial-in parallel-out latch
package sipo_latch_pkg;
    localparam int unsigned WIDTH      = 8;            // Stage count of both registers
    localparam logic [7:0]  STAGE_ZERO = 8'h00;        // Cleared / reset stage value
    localparam int unsigned LAST_STAGE = WIDTH - 1;    // Index of the cascade stage
    localparam int unsigned SYNC_DEPTH = 2;            // Flip-flops in each synchroniser
    localparam int unsigned BUF_DEPTH  = 2;            // Entries in the snapshot buffer
endpackage

// [tb/host_model.sv]
// Host controller model driving the serial link, storage clock, clear and output enable
`timescale 1ns/10ps
module host_model (
    output logic shift_clock_out,   // Link clock, stands low between frames
    output logic shift_data_out,    // Serial data
    output logic shift_clear_n_out, // Shift clear, active low
    output logic store_clock_out,   // Storage clock
    output logic out_en_n_out       // Output enable, active low
);
    initial begin
        {shift_clock_out, shift_data_out, store_clock_out} = 3'h0;
        {shift_clear_n_out, out_en_n_out} = 2'h2;
    end
    // One 30 ns link period; st raises the storage clock on the same edge when clocks are tied
    task automatic shift_bit(input logic b, input logic st);
        shift_data_out = b;
        #15 shift_clock_out = 1'b1;
        store_clock_out = st;
        #15 shift_clock_out = 1'b0;
        shift_data_out = ~b;        // Line no longer held, so it shows the inverse
    endtask
    // Oldest bit first, so it ends in the last stage
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) shift_bit(v[i], 1'b0);
    endtask
    // Storage pulses keep 300 ns high and low, data settled 400 ns before the edge
    task automatic store_low();
        #300 store_clock_out = 1'b0;
        #300;
    endtask
    task automatic store_pulse();
        #400 store_clock_out = 1'b1;
        store_low();
    endtask
    task automatic set_pins(input logic clr_n, input logic oe_n);
        shift_clear_n_out = clr_n;
        out_en_n_out = oe_n;
    endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the serial-in parallel-out latch
`timescale 1ns/10ps
module tb;
    import sipo_latch_pkg::*;
    logic core_clk_in, rst_in, clk_en_in, sink_ready_in, sck, sdi, clr_n, stc, oe_n;
    logic [WIDTH-1:0] par_data_out, par_oe_out;
    logic ser_cascade_out, word_valid_out, snap_ready_out;
    int failures = 0, comparisons = 0;
    logic [7:0] v, e;
    host_model i_host_model (.shift_clock_out(sck), .shift_data_out(sdi), .shift_clear_n_out(clr_n),
        .store_clock_out(stc), .out_en_n_out(oe_n));
    sipo_latch i_sipo_latch (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
        .shift_clock_in(sck), .shift_data_in(sdi), .shift_clear_n_in(clr_n), .store_clock_in(stc),
        .out_en_n_in(oe_n), .sink_ready_in(sink_ready_in), .par_data_out(par_data_out),
        .par_oe_out(par_oe_out), .ser_cascade_out(ser_cascade_out), .word_valid_out(word_valid_out),
        .snap_ready_out(snap_ready_out));
    always #50 core_clk_in = ~core_clk_in;
    //****************************************
    // Shared helpers
    //****************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic end_sim();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Plain shift, store and cascade output
    task automatic t_basic();
        i_host_model.set_pins(1'b1, 1'b0);
        i_host_model.send_byte(8'hA5);
        i_host_model.store_pulse();
        wait_cyc(3);
        chk("par_data", 8'hA5, par_data_out);
        chk("cascade", 8'h01, {7'h00, ser_cascade_out});
        chk("par_oe", 8'hFF, par_oe_out);
    endtask
    // Clear zeroes stages but leaves the storage word until the next store
    task automatic t_clear();
        i_host_model.set_pins(1'b0, 1'b0);
        i_host_model.shift_bit(1'b1, 1'b0);
        i_host_model.shift_bit(1'b1, 1'b0);
        wait_cyc(4);
        chk("cascade", 8'h00, {7'h00, ser_cascade_out});
        chk("par_data", 8'hA5, par_data_out);
        i_host_model.set_pins(1'b1, 1'b0);
        i_host_model.store_pulse();
        wait_cyc(3);
        chk("par_data", 8'h00, par_data_out);
    endtask
    // Tied clocks: storage gets the state from before the shared edge
    task automatic t_tied();
        i_host_model.send_byte(8'h3C);
        #400 i_host_model.shift_bit(1'b1, 1'b1);
        i_host_model.store_low();
        wait_cyc(2);
        chk("par_data", 8'h3C, par_data_out);
        i_host_model.store_pulse();
        wait_cyc(3);
        chk("par_data", 8'h79, par_data_out);
    endtask
    // Receiver stalls until the buffer refuses, then drains; storage word plus BUF_DEPTH snapshots survive
    task automatic t_buffer();
        sink_ready_in = 1'b0;
        v = 8'h00;
        for (int k = 0; k < 4; k++) begin
            v = v + 8'h11;
            i_host_model.send_byte(v);
            i_host_model.store_pulse();
            wait_cyc(3);
        end
        e = 8'(8'h11 * (BUF_DEPTH + 1));
        chk("snap_ready", 8'h00, {7'h00, snap_ready_out});
        chk("word_valid", 8'h01, {7'h00, word_valid_out});
        chk("par_data", 8'h11, par_data_out);
        sink_ready_in = 1'b1;
        wait_cyc(8);
        chk("par_data", e, par_data_out);
        chk("snap_ready", 8'h01, {7'h00, snap_ready_out});
        chk("word_valid", 8'h00, {7'h00, word_valid_out});
    endtask
    // Mid-run reset returns the core outputs to their idle values
    task automatic t_reset();
        rst_in = 1'b1;
        wait_cyc(2);
        chk("par_data", 8'h00, par_data_out);
        chk("word_valid", 8'h00, {7'h00, word_valid_out});
        chk("snap_ready", 8'h01, {7'h00, snap_ready_out});
        chk("par_oe", 8'h00, par_oe_out);
        rst_in = 1'b0;
        wait_cyc(4);
    endtask
    // Output enable follows its pin; a low clock enable freezes the outputs
    task automatic t_oe();
        clk_en_in = 1'b0;
        i_host_model.set_pins(1'b1, 1'b1);
        wait_cyc(5);
        chk("par_oe", 8'hFF, par_oe_out);
        clk_en_in = 1'b1;
        wait_cyc(5);
        chk("par_oe", 8'h00, par_oe_out);
        i_host_model.set_pins(1'b1, 1'b0);
        wait_cyc(5);
        chk("par_oe", 8'hFF, par_oe_out);
    endtask
    initial begin
        {core_clk_in, rst_in, clk_en_in, sink_ready_in} = 4'h7;
        wait_cyc(1);
        i_host_model.set_pins(1'b0, 1'b0);
        wait_cyc(19);
        rst_in = 1'b0;
        i_host_model.set_pins(1'b1, 1'b0);
        wait_cyc(3);
        t_basic();
        t_clear();
        t_tied();
        t_buffer();
        t_reset();
        t_oe();
        end_sim();
    end
    // Watchdog well past the expected run of about 17 us
    initial begin
        #2000000;
        failures++;
        end_sim();
    end
endmodule
